// File: rtl/i2c_master.sv
// Master-only two-wire serial controller with register port
// Assumes pull-ups on both lines and slaves that may stretch the clock
//
// Overview of operation
// - Bytes go out and come in most significant bit first.
// - Both lines are only ever pulled low or released.
// - This controller alone drives the clock for every transfer.
// - After releasing the clock, wait until it reads high before going on.
// - Transfers are whole bytes with no limit on their count.
// - Data changes mid clock-low and is sampled mid clock-high.
// - Four interrupt sources are ORed into one request output.
// - Transmit interrupt needs global and transmit enables.
// - Receive and not-acknowledge interrupts need only the global enable.
// - Rate generator interrupt needs its enable and the global enable.
// - Missing or sent not-acknowledge without start or stop sets a flag.
// - That flag clears only when software sets start or stop.
// - After not-acknowledge the bus waits for start or stop.
// - Receive-full flag sets during the received byte's acknowledge.
// - Reading the data register clears receive-full.
// - After a received byte, stall until receive-full is cleared.
// - Transmit interrupt when enabled, transmit empty and enabled by bit.
`timescale 1ns/100ps
`include "i2c_ctrl_map.svh"
module i2c_master
  import i2c_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Serial clock pin
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe_n,
  // Serial data pin
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  // Interrupt request
  output logic o_irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  baud_if bif ();

  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
  localparam byte_t ctrl_rst_c = `I2C_CTRL_RST;
  logic en_r, global_irq_enable_r, start_r, stop_r, nak_r;
  logic baud_gen_irq_enable_r, tx_irq_enable_r;
  logic [15:0] rate_r;
  byte_t tx_data_r, rx_data_r, sh_r, rdata_r;
  logic tx_empty_flag_r, rx_full_flag_r, nack_r;
  bus_state_t state_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic rd_mode_r, first_r, ack_in_r, nak_hold_r;
  logic scl_oe_n_r, sda_oe_n_r, pin_lvl_r, irq_r;
  logic load_ev_r, rx_ev_r, nack_ev_r, start_done_r, stop_done_r;
  logic wr_ctrl, wr_data, rd_data, adv, out_en, nak_seen;

  // ----------------------------------------
  // Rate generator
  // ----------------------------------------
  assign bif.reload = rate_r;
  assign bif.run = en_r | baud_gen_irq_enable_r;

  baud_rate_generator u_rate (
    .i_clk (i_clk),
    .i_resetn (i_resetn),
    .bif (bif)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= i_scl;
      scl_s_r <= scl_m_r;
      sda_m_r <= i_sda;
      sda_s_r <= sda_m_r;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign wr_ctrl = i_wr && i_addr == `I2C_OFS_CTRL;
  assign wr_data = i_wr && i_addr == `I2C_OFS_DATA;
  assign rd_data = i_rd && i_addr == `I2C_OFS_DATA;
  // Quarter step, held while a released clock still reads low
  assign adv = bif.tick && !(scl_oe_n_r && !scl_s_r);
  // Shifter drives data on writes and on the address byte
  assign out_en = !rd_mode_r || first_r;
  assign nak_seen = out_en ? ack_in_r : nak_r;

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      en_r <= ctrl_rst_c[`I2C_CTL_EN];
      global_irq_enable_r <= ctrl_rst_c[`I2C_CTL_GLOBAL_IRQ_ENABLE];
      baud_gen_irq_enable_r <= ctrl_rst_c[`I2C_CTL_BAUD_GEN_IRQ_ENABLE];
      tx_irq_enable_r <= ctrl_rst_c[`I2C_CTL_TX_IRQ_ENABLE];
      nak_r <= ctrl_rst_c[`I2C_CTL_NAK];
    end else if (wr_ctrl) begin
      en_r <= i_wdata[`I2C_CTL_EN];
      global_irq_enable_r <= i_wdata[`I2C_CTL_GLOBAL_IRQ_ENABLE];
      baud_gen_irq_enable_r <= i_wdata[`I2C_CTL_BAUD_GEN_IRQ_ENABLE];
      tx_irq_enable_r <= i_wdata[`I2C_CTL_TX_IRQ_ENABLE];
      nak_r <= i_wdata[`I2C_CTL_NAK];
    end
  end

  // Start and stop requests, cleared once done
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      start_r <= ctrl_rst_c[`I2C_CTL_START];
      stop_r <= ctrl_rst_c[`I2C_CTL_STOP];
    end else begin
      if (start_done_r) begin
        start_r <= 1'b0;
      end
      if (stop_done_r) begin
        stop_r <= 1'b0;
      end
      if (wr_ctrl && i_wdata[`I2C_CTL_START]) begin
        start_r <= 1'b1;
      end
      if (wr_ctrl && i_wdata[`I2C_CTL_STOP]) begin
        stop_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Rate and transmit data registers
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rate_r <= `I2C_RATE_RST;
    end else if (i_wr && i_addr == `I2C_OFS_RATE_HI) begin
      rate_r[15:8] <= i_wdata;
    end else if (i_wr && i_addr == `I2C_OFS_RATE_LO) begin
      rate_r[7:0] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_data_r <= `I2C_DATA_RST;
    end else if (wr_data) begin
      tx_data_r <= i_wdata;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_empty_flag_r <= 1'b1;
    end else if (wr_data) begin
      tx_empty_flag_r <= 1'b0;
    end else if (load_ev_r) begin
      tx_empty_flag_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_full_flag_r <= 1'b0;
    end else if (rx_ev_r) begin
      rx_full_flag_r <= 1'b1;
    end else if (rd_data) begin
      rx_full_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      nack_r <= 1'b0;
    end else if (nack_ev_r) begin
      nack_r <= 1'b1;
    end else if (wr_ctrl && (i_wdata[`I2C_CTL_START] ||
                             i_wdata[`I2C_CTL_STOP])) begin
      nack_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Bus engine
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rx_data_r <= `I2C_DATA_RST;
      rd_mode_r <= 1'b0;
      first_r <= 1'b0;
      ack_in_r <= 1'b1;
      nak_hold_r <= 1'b0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      load_ev_r <= 1'b0;
      rx_ev_r <= 1'b0;
      nack_ev_r <= 1'b0;
      start_done_r <= 1'b0;
      stop_done_r <= 1'b0;
    end else begin
      load_ev_r <= 1'b0;
      rx_ev_r <= 1'b0;
      nack_ev_r <= 1'b0;
      start_done_r <= 1'b0;
      stop_done_r <= 1'b0;
      if (!en_r) begin
        state_r <= ST_IDLE;
        scl_oe_n_r <= 1'b1;
        sda_oe_n_r <= 1'b1;
        nak_hold_r <= 1'b0;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            if (start_r && !tx_empty_flag_r) begin
              state_r <= ST_START;
              ph_r <= 2'h0;
            end
          end
          ST_START: begin
            if (adv) begin
              ph_r <= ph_r + 2'h1;
              unique case (ph_r)
                2'h0: sda_oe_n_r <= 1'b1;
                2'h1: scl_oe_n_r <= 1'b1;
                2'h2: sda_oe_n_r <= 1'b0;
                2'h3: begin
                  scl_oe_n_r <= 1'b0;
                  start_done_r <= 1'b1;
                  load_ev_r <= 1'b1;
                  sh_r <= tx_data_r;
                  rd_mode_r <= tx_data_r[0];
                  first_r <= 1'b1;
                  bit_r <= 4'h0;
                  state_r <= ST_BIT;
                end
              endcase
            end
          end
          ST_BIT: begin
            if (adv) begin
              ph_r <= ph_r + 2'h1;
              unique case (ph_r)
                2'h0: begin
                  // Data changes mid clock-low
                  if (bit_r != `I2C_ACK_BIT) begin
                    sda_oe_n_r <= out_en ? sh_r[7] : 1'b1;
                  end else begin
                    sda_oe_n_r <= out_en ? 1'b1 : nak_r;
                    if (!out_en) begin
                      rx_ev_r <= 1'b1;
                      rx_data_r <= sh_r;
                    end
                  end
                end
                2'h1: scl_oe_n_r <= 1'b1;
                2'h2: begin
                  // Sampled mid clock-high
                  if (bit_r != `I2C_ACK_BIT) begin
                    sh_r <= {sh_r[6:0], sda_s_r};
                  end else begin
                    ack_in_r <= sda_s_r;
                  end
                end
                2'h3: begin
                  scl_oe_n_r <= 1'b0;
                  if (bit_r != `I2C_ACK_BIT) begin
                    bit_r <= bit_r + 4'h1;
                  end else begin
                    first_r <= 1'b0;
                    state_r <= ST_HOLD;
                    if (nak_seen && !start_r && !stop_r) begin
                      nack_ev_r <= 1'b1;
                      nak_hold_r <= 1'b1;
                    end
                  end
                end
              endcase
            end
          end
          ST_HOLD: begin
            sda_oe_n_r <= 1'b1;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            if (rd_mode_r && rx_full_flag_r) begin
              state_r <= ST_HOLD;
            end else if (stop_r) begin
              nak_hold_r <= 1'b0;
              state_r <= ST_STOP;
            end else if (start_r) begin
              nak_hold_r <= 1'b0;
              if (!tx_empty_flag_r) begin
                state_r <= ST_START;
              end
            end else if (nak_hold_r) begin
              state_r <= ST_HOLD;
            end else if (rd_mode_r) begin
              state_r <= ST_BIT;
            end else if (!tx_empty_flag_r) begin
              sh_r <= tx_data_r;
              load_ev_r <= 1'b1;
              state_r <= ST_BIT;
            end
          end
          ST_STOP: begin
            if (adv) begin
              ph_r <= ph_r + 2'h1;
              unique case (ph_r)
                2'h0: sda_oe_n_r <= 1'b0;
                2'h1: scl_oe_n_r <= 1'b1;
                2'h2: begin
                  sda_oe_n_r <= 1'b1;
                  stop_done_r <= 1'b1;
                  state_r <= ST_IDLE;
                end
                2'h3: state_r <= ST_IDLE;
              endcase
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Open-drain level
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_lvl_r <= 1'b0;
    end else begin
      pin_lvl_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= global_irq_enable_r && (
        (tx_irq_enable_r && en_r && tx_empty_flag_r) ||
        rx_full_flag_r || nack_r ||
        (baud_gen_irq_enable_r && bif.tick));
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `I2C_OFS_DATA: rdata_r <= rx_data_r;
        `I2C_OFS_STAT: rdata_r <= {tx_empty_flag_r, rx_full_flag_r,
                                   nack_r, state_r != ST_IDLE,
                                   rd_mode_r, 3'h0};
        `I2C_OFS_CTRL: rdata_r <= {global_irq_enable_r, start_r, stop_r,
                                   baud_gen_irq_enable_r, tx_irq_enable_r,
                                   nak_r, 1'b0, en_r};
        `I2C_OFS_RATE_HI: rdata_r <= rate_r[15:8];
        `I2C_OFS_RATE_LO: rdata_r <= rate_r[7:0];
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_rdata = rdata_r;
  assign o_scl = pin_lvl_r;
  assign o_sda = pin_lvl_r;
  assign o_scl_oe_n = scl_oe_n_r;
  assign o_sda_oe_n = sda_oe_n_r;
  assign o_irq = irq_r;

endmodule // i2c_master

// File: rtl/i2c_ctrl_map.svh
// Register offsets, field positions, reset values and counts
// Assumes inclusion by every file that touches the register map
`ifndef I2C_CTRL_MAP_SVH
`define I2C_CTRL_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define I2C_OFS_DATA 3'h0
`define I2C_OFS_STAT 3'h1
`define I2C_OFS_CTRL 3'h2
`define I2C_OFS_RATE_HI 3'h3
`define I2C_OFS_RATE_LO 3'h4

// ----------------------------------------
// Control fields
// ----------------------------------------
`define I2C_CTL_GLOBAL_IRQ_ENABLE 7
`define I2C_CTL_START 6
`define I2C_CTL_STOP 5
`define I2C_CTL_BAUD_GEN_IRQ_ENABLE 4
`define I2C_CTL_TX_IRQ_ENABLE 3
`define I2C_CTL_NAK 2
`define I2C_CTL_EN 0

// ----------------------------------------
// Status fields
// ----------------------------------------
`define I2C_STA_TX_EMPTY_FLAG 7
`define I2C_STA_RX_FULL_FLAG 6
`define I2C_STA_NCK 5
`define I2C_STA_BUSY 4
`define I2C_STA_RD 3

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define I2C_CTRL_RST 8'h00
`define I2C_DATA_RST 8'h00
`define I2C_RATE_RST 16'h0064
`define I2C_ACK_BIT 4'h8

`endif

// File: rtl/i2c_ctrl_pkg.sv
// Types shared by the controller and its rate generator
// Assumes the map header for all numeric constants
package i2c_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_HOLD,
    ST_STOP
  } bus_state_t;

  typedef logic [7:0] byte_t;

endpackage

// File: rtl/baud_if.sv
// Link between the controller and its quarter-bit rate generator
// Assumes one clock shared by both ends
`timescale 1ns/100ps
interface baud_if;
  logic [15:0] reload;
  logic run;
  logic tick;
  modport gen (input reload, input run, output tick);
  modport user (output reload, output run, input tick);
endinterface

// File: rtl/baud_rate_generator.sv
// Down counter giving a one-cycle tick every reload clocks
// Assumes reload zero means the longest period
`timescale 1ns/100ps
module baud_rate_generator
  import i2c_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Rate link
  baud_if.gen bif
);

  logic [15:0] cnt_r;
  logic tick_r;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 16'h0000;
    end else if (!bif.run || cnt_r == 16'h0000) begin
      cnt_r <= bif.reload - 16'h0001;
    end else begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // ----------------------------------------
  // Tick pulse
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= bif.run && cnt_r == 16'h0000;
    end
  end

  assign bif.tick = tick_r;

endmodule // baud_rate_generator

// File: sim/i2c_master_sva.sv
// Port checks for the two-wire master controller
// Assumes one clock domain and open-drain wires built by the bench
`timescale 1ns/100ps
`include "i2c_ctrl_map.svh"
module i2c_master_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Lines and request
  input wire logic i_scl,
  input wire logic o_scl,
  input wire logic o_scl_oe_n,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe_n,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic global_irq_enable_r;
  // --------------
  // Enable shadow
  // --------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) global_irq_enable_r <= 1'b0;
    else if (i_wr && i_addr == `I2C_OFS_CTRL)
      global_irq_enable_r <= i_wdata[`I2C_CTL_GLOBAL_IRQ_ENABLE];
  end
  property p_scl_od;
    !o_scl_oe_n |-> !o_scl;
  endproperty
  a_scl_od: assert property (p_scl_od)
    else $error("clock line driven high");
  property p_sda_od;
    !o_sda_oe_n |-> !o_sda;
  endproperty
  a_sda_od: assert property (p_sda_od)
    else $error("data line driven high");
  property p_clk_src;
    $fell(i_scl) |-> !o_scl_oe_n;
  endproperty
  a_clk_src: assert property (p_clk_src)
    else $error("clock fell without the master");
  property p_stretch;
    (o_scl_oe_n && !i_scl)[*3] |=> o_scl_oe_n && $stable(o_sda_oe_n);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("moved on while clock held low");
  property p_mid_low;
    $changed(o_scl_oe_n) |-> $stable(o_sda_oe_n);
  endproperty
  a_mid_low: assert property (p_mid_low)
    else $error("data moved on a clock edge");
  property p_irq_gate;
    !global_irq_enable_r ##1 !global_irq_enable_r |-> !o_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("request without global enable");
  property p_rx_clr;
    i_rd && i_addr == `I2C_OFS_DATA ##2 i_rd && i_addr == `I2C_OFS_STAT
      |=> !o_rdata[`I2C_STA_RX_FULL_FLAG];
  endproperty
  a_rx_clr: assert property (p_rx_clr)
    else $error("receive full kept after data read");
  property p_tx_clr;
    i_wr && i_addr == `I2C_OFS_DATA ##2 i_rd && i_addr == `I2C_OFS_STAT
      |=> !o_rdata[`I2C_STA_TX_EMPTY_FLAG];
  endproperty
  a_tx_clr: assert property (p_tx_clr)
    else $error("transmit empty kept after data write");
endmodule // i2c_master_sva

bind i2c_master i2c_master_sva sva_u (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq));

// File: sim/i2c_slave_model.sv
// Behavioural slave on the two-wire bus
// Assumes pull-ups on both wires in the bench
`timescale 1ns/100ps
module i2c_slave_model (
  // Wires
  input wire logic i_scl,
  input wire logic i_sda,
  // Behaviour
  input wire logic i_stretch,
  input wire logic i_nack,
  input wire logic [7:0] i_rbyte,
  // Pull-downs and capture
  output logic o_scl_low,
  output logic o_sda_low,
  output logic [7:0] o_got
);
  logic [7:0] sh_r = 8'h00;
  logic [3:0] cnt_r = 4'h8;
  logic first_r = 1'b0;
  logic rd_r = 1'b0;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_got = 8'h00;
  end
  // Start restarts the byte count
  always @(negedge i_sda) begin
    if (i_scl) begin
      cnt_r = 4'h8;
      first_r = 1'b1;
    end
  end
  // Sample on the rising clock edge, first bit is the top bit
  always @(posedge i_scl) sh_r = {sh_r[6:0], i_sda};
  always @(negedge i_scl) begin
    #30;
    cnt_r = (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
    if (cnt_r == 4'h8) begin
      if (first_r || !rd_r) begin
        if (first_r) rd_r = sh_r[0];
        o_got = sh_r;
        o_sda_low = !i_nack;
      end else begin
        o_sda_low = 1'b0;
      end
      first_r = 1'b0;
    end else begin
      o_sda_low = rd_r && !first_r && !i_rbyte[3'd7 - cnt_r[2:0]];
    end
    if (i_stretch) begin
      o_scl_low = 1'b1;
      #400;
      o_scl_low = 1'b0;
    end
  end
endmodule // i2c_slave_model

// File: sim/tb_top.sv
// Self-checking bench for the two-wire master controller
// Assumes the map header and a slave model on pulled-up wires
`timescale 1ns/100ps
`include "i2c_ctrl_map.svh"
module tb_top
  import i2c_ctrl_pkg::*;
();
  typedef struct packed {logic wr; logic [2:0] a; byte_t d;} row_t;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [2:0] i_addr = 3'h0;
  byte_t i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic stretch = 1'b0;
  logic nack = 1'b0;
  byte_t o_rdata, got, d;
  logic o_scl, o_scl_oe_n, o_sda, o_sda_oe_n, o_irq;
  logic scl_low, sda_low, scl_w, sda_w;
  int miscompares = 0;
  int tests_run = 0;
  row_t rows [0:10];
  assign scl_w = (o_scl_oe_n ? 1'b1 : o_scl) & !scl_low;
  assign sda_w = (o_sda_oe_n ? 1'b1 : o_sda) & !sda_low;
  i2c_master dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_scl(scl_w), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .i_sda(sda_w),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq));
  i2c_slave_model slave_u (.i_scl(scl_w), .i_sda(sda_w), .i_stretch(stretch),
    .i_nack(nack), .i_rbyte(8'hc6), .o_scl_low(scl_low), .o_sda_low(sda_low),
    .o_got(got));
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // ------------
  // Bench tasks
  // ------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input byte_t s, input byte_t e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input byte_t v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output byte_t v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic poll(input int b, input logic v, input string n);
    byte_t s;
    int k;
    k = 0;
    rd(`I2C_OFS_STAT, s);
    while (s[b] !== v && k < 400) begin
      rd(`I2C_OFS_STAT, s);
      k++;
    end
    chk(n, {7'h00, s[b]}, {7'h00, v});
  endtask
  task automatic irq_seen(input int n, input logic e, input string nm);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      #1 seen = seen | o_irq;
    end
    chk(nm, {7'h00, seen}, {7'h00, e});
  endtask
  task automatic quiet(input string nm);
    logic s0;
    logic moved;
    repeat (20) @(posedge i_clk);
    s0 = scl_w;
    moved = 1'b0;
    repeat (60) begin
      @(posedge i_clk);
      moved = moved | (scl_w !== s0);
    end
    chk(nm, {7'h00, moved}, 8'h00);
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    rows = '{'{1'b0, `I2C_OFS_STAT, 8'h80}, '{1'b0, `I2C_OFS_CTRL, 8'h00},
      '{1'b0, `I2C_OFS_RATE_HI, 8'h00}, '{1'b0, `I2C_OFS_RATE_LO, 8'h64},
      '{1'b0, `I2C_OFS_DATA, 8'h00}, '{1'b1, 3'h5, 8'hff},
      '{1'b0, 3'h5, 8'h00}, '{1'b1, `I2C_OFS_RATE_LO, 8'h02},
      '{1'b0, `I2C_OFS_RATE_LO, 8'h02}, '{1'b1, `I2C_OFS_CTRL, 8'h18},
      '{1'b0, `I2C_OFS_CTRL, 8'h18}};
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else begin
        rd(rows[i].a, d);
        chk("reg", d, rows[i].d);
      end
    end
    wr(`I2C_OFS_CTRL, 8'h88);
    irq_seen(8, 1'b0, "tx irq disabled");
    wr(`I2C_OFS_CTRL, 8'h89);
    irq_seen(8, 1'b1, "tx irq");
    wr(`I2C_OFS_CTRL, 8'h09);
    irq_seen(8, 1'b0, "tx irq no global");
    wr(`I2C_OFS_CTRL, 8'h81);
    irq_seen(8, 1'b0, "tx irq no txi");
    wr(`I2C_OFS_DATA, 8'ha0);
    rd(`I2C_OFS_STAT, d);
    chk("tx empty", {7'h00, d[`I2C_STA_TX_EMPTY_FLAG]}, 8'h00);
    wr(`I2C_OFS_CTRL, 8'h91);
    irq_seen(20, 1'b1, "rate irq");
    wr(`I2C_OFS_CTRL, 8'h11);
    irq_seen(20, 1'b0, "rate irq no global");
    stretch <= 1'b1;
    wr(`I2C_OFS_CTRL, 8'h41);
    poll(`I2C_STA_TX_EMPTY_FLAG, 1'b1, "addr loaded");
    wr(`I2C_OFS_DATA, 8'h35);
    poll(`I2C_STA_TX_EMPTY_FLAG, 1'b1, "data loaded");
    wr(`I2C_OFS_CTRL, 8'h21);
    poll(`I2C_STA_BUSY, 1'b0, "write done");
    chk("slave byte", got, 8'h35);
    stretch <= 1'b0;
    nack <= 1'b1;
    wr(`I2C_OFS_DATA, 8'ha2);
    wr(`I2C_OFS_CTRL, 8'hc1);
    poll(`I2C_STA_NCK, 1'b1, "nack set");
    irq_seen(4, 1'b1, "nack irq");
    quiet("nack idle");
    rd(`I2C_OFS_STAT, d);
    chk("nack held", {7'h00, d[`I2C_STA_NCK]}, 8'h01);
    nack <= 1'b0;
    wr(`I2C_OFS_CTRL, 8'ha1);
    rd(`I2C_OFS_STAT, d);
    chk("nack cleared", {7'h00, d[`I2C_STA_NCK]}, 8'h00);
    poll(`I2C_STA_BUSY, 1'b0, "stop done");
    wr(`I2C_OFS_DATA, 8'ha1);
    wr(`I2C_OFS_CTRL, 8'hc1);
    poll(`I2C_STA_RX_FULL_FLAG, 1'b1, "rx full");
    irq_seen(4, 1'b1, "rx irq");
    quiet("rx stall");
    wr(`I2C_OFS_CTRL, 8'h85);
    rd(`I2C_OFS_DATA, d);
    chk("rx byte", d, 8'hc6);
    rd(`I2C_OFS_STAT, d);
    chk("rx cleared", {7'h00, d[`I2C_STA_RX_FULL_FLAG]}, 8'h00);
    wr(`I2C_OFS_CTRL, 8'ha5);
    poll(`I2C_STA_RX_FULL_FLAG, 1'b1, "rx full again");
    rd(`I2C_OFS_DATA, d);
    chk("rx last", d, 8'hc6);
    poll(`I2C_STA_BUSY, 1'b0, "read done");
    rd(`I2C_OFS_STAT, d);
    chk("no nack at stop", {7'h00, d[`I2C_STA_NCK]}, 8'h00);
    conclude();
  end
endmodule // tb_top
